// file: inc/dll_pkg.sv
package dll_pkg;

    // ==============================
    // widths and counts
    localparam int CNT_W = 8;                 // phase and period counter width
    localparam int DIV_W = 5;                 // divided-output divisor width
    localparam int NUM_OUTS = 9;              // clock manager outputs competing for global muxes
    localparam int MAX_GLOBAL_MUX = 4;        // concurrent global mux drivers per die edge
    localparam int LOCK_PERIODS = 4;          // aligned periods needed before lock
    localparam logic [DIV_W-1:0] DIV_MIN = 5'h02;     // smallest legal divisor
    localparam logic [DIV_W-1:0] DIV_DEFAULT = 5'h02; // divisor after reset
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;     // counter saturation value

    // ==============================
    // feedback select setting
    typedef enum logic [1:0] {
        FB_NONE,
        FB_1X,
        FB_2X
    } fb_mode_t;

    // ==============================
    // loop state
    typedef enum logic [1:0] {
        ST_MEASURE,
        ST_TRACK,
        ST_LOCKED
    } lock_state_t;

    // ==============================
    // bundle of generated clocks
    typedef struct packed {
        logic phase0;
        logic phase90;
        logic phase180;
        logic phase270;
        logic dbl;
        logic dbl_inv;
        logic divided;
    } clock_outs_t;

endpackage

// file: core/rise_detect.sv
`timescale 1ns/1ns
// ==============================
// rising edge detector for a synchronous input
module rise_detect (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic sig,
    output logic rise
);

    // previous sample of the input
    typedef struct packed {
        logic prev;
    } rise_state_t;

    rise_state_t s_reg;
    rise_state_t s_next;

    // next state and edge pulse
    always_comb begin
        s_next = s_reg;
        s_next.prev = sig;
        rise = sig & ~s_reg.prev;
    end

    // register, frozen while clock enable is low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

endmodule

// file: core/dll_core.sv
`timescale 1ns/1ns
module dll_core #(
    parameter int LOCK_COUNT = dll_pkg::LOCK_PERIODS
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic ref_clock_in,
    input wire logic ref_net_in,
    input wire logic ref_select_net,
    input wire logic feedback_clock_in,
    input wire logic input_halve_enable,
    input wire dll_pkg::fb_mode_t fb_mode,
    input wire logic [dll_pkg::DIV_W-1:0] div_divisor,
    input wire logic [dll_pkg::NUM_OUTS-1:0] global_mux_req,
    output logic out_phase0,
    output logic out_phase90,
    output logic out_phase180,
    output logic out_phase270,
    output logic out_double,
    output logic out_double_inv,
    output logic out_divided,
    output logic [dll_pkg::NUM_OUTS-1:0] global_mux_grant,
    output logic locked
);

    // ==============================
    // state
    typedef struct packed {
        dll_pkg::lock_state_t st;              // loop state
        logic [dll_pkg::CNT_W-1:0] cnt;        // cycles since reference edge
        logic [dll_pkg::CNT_W-1:0] period;     // measured reference period
        logic [dll_pkg::CNT_W-1:0] tap;        // phase advance applied to outputs
        logic [dll_pkg::CNT_W-1:0] fb_age;     // cycles since feedback edge
        logic [dll_pkg::DIV_W-1:0] div_cnt;    // reference periods within divided cycle
        logic [dll_pkg::CNT_W-1:0] good;       // consecutive aligned periods
        logic half;                            // halved reference level
        dll_pkg::clock_outs_t outs;            // generated clocks
        logic [dll_pkg::NUM_OUTS-1:0] grant;   // global mux grants
        logic locked;                          // lock indicator
    } dll_state_t;

    dll_state_t s_reg;
    dll_state_t s_next;

    logic ref_raw;          // selected reference source
    logic ref_rise_raw;     // edge of the selected source
    logic fb_rise;          // edge of the feedback clock

    // global net goes straight to the reference input, no gating
    assign ref_raw = ref_select_net ? ref_net_in : ref_clock_in;

    // ==============================
    // edge detectors
    rise_detect u_ref_rise (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .sig(ref_raw),
        .rise(ref_rise_raw)
    );

    rise_detect u_fb_rise (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .sig(feedback_clock_in),
        .rise(fb_rise)
    );

    // ==============================
    // loop, waveform and grant logic
    always_comb begin
        logic eff_rise;
        logic aligned;
        logic [dll_pkg::CNT_W:0] sum;
        logic [dll_pkg::CNT_W-1:0] p;
        logic [dll_pkg::CNT_W-1:0] p2;
        logic [dll_pkg::CNT_W-1:0] half_p;
        logic [dll_pkg::CNT_W-1:0] quarter_p;
        logic [dll_pkg::CNT_W-1:0] cnt_inc;
        logic [dll_pkg::DIV_W-1:0] divisor;
        logic [dll_pkg::DIV_W:0] div_pos;
        int granted;
        s_next = s_reg;
        eff_rise = 1'b0;
        aligned = 1'b0;
        sum = '0;
        p = '0;
        p2 = '0;
        div_pos = '0;
        granted = 0;
        half_p = s_reg.period >> 1;
        quarter_p = s_reg.period >> 2;
        cnt_inc = s_reg.cnt + 8'h01;
        divisor = (div_divisor < dll_pkg::DIV_MIN) ? dll_pkg::DIV_MIN : div_divisor;
        // halving toggles on every source edge, giving even high and low
        if (ref_rise_raw) begin
            s_next.half = ~s_reg.half;
        end
        // with halving, only every second source edge starts a period
        eff_rise = ref_rise_raw & (~input_halve_enable | ~s_reg.half);
        // feedback edge age, saturating
        if (fb_rise) begin
            s_next.fb_age = '0;
        end else if (s_reg.fb_age != dll_pkg::CNT_MAX) begin
            s_next.fb_age = s_reg.fb_age + 8'h01;
        end
        // period counter restarts at each reference edge
        if (eff_rise) begin
            s_next.cnt = '0;
            s_next.period = cnt_inc;
        end else if (s_reg.cnt != dll_pkg::CNT_MAX) begin
            s_next.cnt = cnt_inc;
        end
        // loop control, one tap step per reference period
        aligned = fb_rise | (s_reg.fb_age == '0);
        if (eff_rise) begin
            unique case (s_reg.st)
                dll_pkg::ST_MEASURE: begin
                    // wait for two equal periods
                    s_next.tap = '0;
                    s_next.good = '0;
                    if (cnt_inc == s_reg.period) begin
                        s_next.st = dll_pkg::ST_TRACK;
                    end
                end
                dll_pkg::ST_TRACK, dll_pkg::ST_LOCKED: begin
                    if (cnt_inc != s_reg.period) begin
                        // reference changed, start again
                        s_next.st = dll_pkg::ST_MEASURE;
                        s_next.good = '0;
                    end else if (fb_mode == dll_pkg::FB_NONE) begin
                        // no feedback loop, lock on stable period
                        s_next.st = dll_pkg::ST_LOCKED;
                    end else if (aligned) begin
                        // either feedback wiring lands on the reference edge
                        if (s_reg.good >= 8'(LOCK_COUNT - 1)) begin
                            s_next.st = dll_pkg::ST_LOCKED;
                        end else begin
                            s_next.good = s_reg.good + 8'h01;
                        end
                    end else begin
                        // misaligned: drop lock and move one tap
                        s_next.st = dll_pkg::ST_TRACK;
                        s_next.good = '0;
                        if (s_reg.fb_age < half_p) begin
                            // feedback early, delay outputs
                            s_next.tap = (s_reg.tap == '0) ? s_reg.period - 8'h01 : s_reg.tap - 8'h01;
                        end else begin
                            // feedback late, advance outputs
                            s_next.tap = (s_reg.tap >= s_reg.period - 8'h01) ? '0 : s_reg.tap + 8'h01;
                        end
                    end
                end
            endcase
        end
        // lock indicator low until the locked state is reached
        s_next.locked = (s_next.st == dll_pkg::ST_LOCKED);
        // all outputs share one advanced phase, so all align together
        sum = {1'b0, s_reg.cnt} + {1'b0, s_reg.tap};
        if (sum >= {1'b0, s_reg.period}) begin
            sum = sum - {1'b0, s_reg.period};
        end
        p = sum[dll_pkg::CNT_W-1:0];
        // quadrant outputs from the phase position
        s_next.outs.phase0 = (p < half_p);
        s_next.outs.phase90 = (p >= quarter_p) && (p < half_p + quarter_p);
        s_next.outs.phase180 = ~(p < half_p);
        s_next.outs.phase270 = ~((p >= quarter_p) && (p < half_p + quarter_p));
        // doubled outputs fold the period in two
        p2 = (p >= half_p) ? p - half_p : p;
        s_next.outs.dbl = (p2 < quarter_p);
        s_next.outs.dbl_inv = ~(p2 < quarter_p);
        // divided count steps where the output phase wraps, so halves stay whole under any tap
        if (p == s_reg.period - 8'h01) begin
            s_next.div_cnt = (s_reg.div_cnt >= divisor - 5'h01) ? '0 : s_reg.div_cnt + 5'h01;
        end
        // divided output counts half periods for even duty with odd divisors
        div_pos = {s_reg.div_cnt, (p >= half_p)};
        s_next.outs.divided = (div_pos < {1'b0, divisor});
        // grant global mux requests in index order, at most four
        for (int i = 0; i < dll_pkg::NUM_OUTS; i++) begin
            s_next.grant[i] = 1'b0;
            if (global_mux_req[i] && granted < dll_pkg::MAX_GLOBAL_MUX) begin
                s_next.grant[i] = 1'b1;
                granted = granted + 1;
            end
        end
    end

    // register, frozen while clock enable is low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    // ==============================
    // outputs straight from flops, all driven at once
    assign out_phase0 = s_reg.outs.phase0;
    assign out_phase90 = s_reg.outs.phase90;
    assign out_phase180 = s_reg.outs.phase180;
    assign out_phase270 = s_reg.outs.phase270;
    assign out_double = s_reg.outs.dbl;
    assign out_double_inv = s_reg.outs.dbl_inv;
    assign out_divided = s_reg.outs.divided;
    assign global_mux_grant = s_reg.grant;
    assign locked = s_reg.locked;

endmodule

// file: tb/fb_network.sv
`timescale 1ns/1ns
// ==============================
// clock network: returns a chosen output after a skew
module fb_network (
    input wire logic clk,
    input wire logic out_phase0,
    input wire logic out_double,
    input wire logic use_double,
    input wire logic loop_on,
    input wire logic [3:0] skew,
    output logic feedback_clock_in
);
    logic [15:0] line_reg = '0; // delayed copies of the returned clock
    // sample away from the design's edge
    always @(negedge clk) begin
        line_reg <= {line_reg[14:0], use_double ? out_double : out_phase0};
    end
    // no return path when only synthesis is used
    assign feedback_clock_in = loop_on & line_reg[skew];
endmodule

// file: tb/dll_core_asserts.sv
`timescale 1ns/1ns
// ==============================
// port checks for the loop core
module dll_core_asserts (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [dll_pkg::NUM_OUTS-1:0] global_mux_req,
    input wire logic [dll_pkg::NUM_OUTS-1:0] global_mux_grant,
    input wire logic out_phase0,
    input wire logic out_phase90,
    input wire logic out_phase180,
    input wire logic out_phase270,
    input wire logic out_double,
    input wire logic out_double_inv,
    input wire logic locked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_GRANT_MAX: assert property ($countones(global_mux_grant) <= dll_pkg::MAX_GLOBAL_MUX)
        else $error("too many grants");
    AST_GRANT_ONLY_REQ: assert property ($past(arst_n) |-> (global_mux_grant & ~$past(global_mux_req)) == '0)
        else $error("grant without request");
    AST_GRANT_FOLLOW: assert property ($past(arst_n) && $countones($past(global_mux_req)) <= 4
        |-> global_mux_grant == $past(global_mux_req)) else $error("grant not following request");
    AST_HALF_INV: assert property (locked |-> out_phase180 == !out_phase0)
        else $error("half period output wrong");
    AST_Q270_INV: assert property (locked |-> out_phase270 == !out_phase90)
        else $error("270 output wrong");
    AST_DBL_INV: assert property (locked |-> out_double_inv == !out_double)
        else $error("inverted double wrong");
    AST_DBL_ALIGN: assert property (locked && $rose(out_phase0) |-> $rose(out_double))
        else $error("double not in phase");
    AST_Q90_LAG: assert property (locked && $rose(out_phase90) |-> out_phase0 && $past(out_phase0))
        else $error("90 output not lagging");
    AST_LOCK_LOW: assert property ($rose(arst_n) |-> !locked [*8])
        else $error("lock too early after reset");
    cover property ($rose(locked));
    cover property ($fell(locked));
    cover property ($countones(global_mux_grant) == 4);
endmodule
bind dll_core dll_core_asserts u_chk (.clk, .arst_n, .global_mux_req, .global_mux_grant, .out_phase0,
    .out_phase90, .out_phase180, .out_phase270, .out_double, .out_double_inv, .locked);

// file: tb/dll_clock_feedback_phase_outputs_test.sv
`timescale 1ns/1ns
module dll_clock_feedback_phase_outputs_test;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ref_a = 1'b0, ref_b = 1'b0, sel_net = 1'b0, halve = 1'b0, use_dbl = 1'b0, loop_on = 1'b0, fb;
    dll_pkg::fb_mode_t mode = dll_pkg::FB_NONE;
    logic [4:0] divisor = 5'h02;
    logic [8:0] req = 9'h000, grant;
    logic [3:0] skew = 4'h0;
    logic p0, p90, p180, p270, dbl, dbli, dv, locked;
    wire [6:0] wv = {dbli, p270, p180, p90, dv, dbl, p0};
    int err_total = 0, check_count = 0, seed = 76275, pin = 8, rc = 0, per, hi, i, n, eff, d;
    int pins[4] = '{8, 16, 4, 12};
    always #4 clk = ~clk;
    dll_core #(.LOCK_COUNT(2)) u_dut (.clk(clk), .arst_n(arst_n), .clk_en(1'b1), .ref_clock_in(ref_a),
        .ref_net_in(ref_b), .ref_select_net(sel_net), .feedback_clock_in(fb), .input_halve_enable(halve),
        .fb_mode(mode), .div_divisor(divisor), .global_mux_req(req), .out_phase0(p0), .out_phase90(p90),
        .out_phase180(p180), .out_phase270(p270), .out_double(dbl), .out_double_inv(dbli),
        .out_divided(dv), .global_mux_grant(grant), .locked(locked));
    fb_network u_fb (.clk(clk), .out_phase0(p0), .out_double(dbl), .use_double(use_dbl),
        .loop_on(loop_on), .skew(skew), .feedback_clock_in(fb));
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    // verdict and end of run
    task automatic results();
        if (err_total == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // period and high time of one output, rise to rise
    task automatic meas(input int k, output int per, output int hi);
        int t, st;
        per = 0;
        hi = 0;
        st = 0;
        for (t = 0; t < 4000 && st < 4; t++) begin
            @(negedge clk);
            if (st == 0 && !wv[k]) st = 1;
            else if (st == 1 && wv[k]) st = 2;
            else if (st == 2 && !wv[k]) st = 3;
            else if (st == 3 && wv[k]) st = 4;
            if (st == 2 || st == 3) per++;
            if (st == 2) hi++;
        end
        if (st < 4) begin
            err_total++;
            results();
        end
    endtask
    // cycles from a rise of one output to the next rise of another
    task automatic lag(input int a, input int b, output int dl);
        int t, st;
        logic pb, rb;
        dl = 0;
        st = 0;
        pb = wv[b];
        for (t = 0; t < 4000 && st < 3; t++) begin
            @(negedge clk);
            rb = wv[b] & ~pb;
            pb = wv[b];
            if (st == 2) begin
                dl++;
                if (rb) st = 3;
            end else if (st == 1 && wv[a]) begin
                st = rb ? 3 : 2;
            end else if (st == 0 && !wv[a]) begin
                st = 1;
            end
        end
        if (st < 3) begin
            err_total++;
            results();
        end
    endtask
    // reference high for two fifths of its period, rounded down to whole cycles, the other source toggling every cycle
    always @(negedge clk) begin
        rc <= rc + 1;
        ref_a <= sel_net ? rc[0] : ((rc % pin) < pin * 2 / 5);
        ref_b <= sel_net ? ((rc % pin) < pin * 2 / 5) : rc[0];
    end
    // grant model: lowest four requests of the previous edge
    always @(negedge clk) begin : gm
        int c;
        logic [8:0] e;
        c = 0;
        e = '0;
        for (int k = 0; k < 9; k++) begin
            if (req[k] && c < dll_pkg::MAX_GLOBAL_MUX) begin
                e[k] = 1'b1;
                c++;
            end
        end
        if (arst_n) check(16'(grant), 16'(e));
        req <= 9'($random(seed));
    end
    // modes: 1x loop, 2x loop, halved input, synthesis only
    initial begin
        for (n = 0; n < 4; n++) begin
            @(negedge clk);
            arst_n <= 1'b0;
            mode <= n == 1 ? dll_pkg::FB_2X : n == 3 ? dll_pkg::FB_NONE : dll_pkg::FB_1X;
            use_dbl <= (n == 1);
            halve <= (n == 2);
            loop_on <= (n != 3);
            pin <= pins[n];
            sel_net <= 1'($random(seed));
            skew <= 4'($random(seed));
            divisor <= 5'h02 + 5'(n);
            eff = pins[n] * (n == 2 ? 2 : 1);
            repeat (8) @(negedge clk);
            arst_n <= 1'b1;
            @(negedge clk);
            check(16'(locked), 16'h0000);
            for (i = 0; i < 4000 && locked !== 1'b1; i++) @(negedge clk);
            check(16'(locked), 16'h0001);
            if (locked !== 1'b1) results();
            meas(0, per, hi);
            check(16'(per), 16'(eff));
            check(16'(hi), 16'(eff / 2));
            meas(1, per, hi);
            check(16'(per), 16'(eff / 2));
            check(16'(hi), 16'(eff / 4));
            meas(2, per, hi);
            check(16'(per), 16'(eff * (n + 2)));
            check(16'(hi), 16'(eff * (n + 2) / 2));
            lag(0, 3, d);
            check(16'(d), 16'(eff / 4));
            lag(0, 4, d);
            check(16'(d), 16'(eff / 2));
            lag(0, 5, d);
            check(16'(d), 16'(eff * 3 / 4));
            lag(0, 1, d);
            check(16'(d), 16'h0000);
            lag(0, 6, d);
            check(16'(d), 16'(eff / 4));
            pin <= pins[n] + 4;
            for (i = 0; i < 200 && locked === 1'b1; i++) @(negedge clk);
            check(16'(locked), 16'h0000);
            if (locked !== 1'b0) results();
        end
        results();
    end
endmodule
